// *** src/fifo_flag_device.sv ***
`timescale 1ns/1ps
`default_nettype none
module fifo_flag_device (
    input  wire logic   clk_sys,
    input  wire logic   rst_n,
    fifo_flag_if.device dev
);
    typedef struct packed {
        logic                  serialLd;
        logic                  fallThru;
        logic [16:0]           emptyOff;
        logic [16:0]           fullOff;
        fifo_flag_pkg::offPtr_t wrPtr;
        fifo_flag_pkg::offPtr_t rdPtr;
        logic [5:0]            serCnt;
        logic [1:0]            settle;
        logic [17:0]           count;
        logic [17:0]           dataOut;
        logic [6:0]            flags;
    } devState_t;

    devState_t   s_q;
    devState_t   s_d;
    logic [6:0]  decFlags;
    logic        offWr;
    logic        offRd;
    logic        serShift;
    logic        memWr;
    logic        memRd;
    logic [18:0] capacity;
    logic [4:0]  serIdx;

    // Readback word for one offset register, upper bits zero
    function automatic logic [17:0] offWord(input fifo_flag_pkg::offPtr_t p,
                                            input logic [16:0] eOff,
                                            input logic [16:0] fOff);
        logic [17:0] w;
        w = 18'h00000;
        case (p)
            fifo_flag_pkg::PTR_EMPTY_LSB: w[8:0] = eOff[8:0];
            fifo_flag_pkg::PTR_EMPTY_MSB: w[7:0] = eOff[16:9];
            fifo_flag_pkg::PTR_FULL_LSB:  w[8:0] = fOff[8:0];
            fifo_flag_pkg::PTR_FULL_MSB:  w[7:0] = fOff[16:9];
            default:                      w = 18'h00000;
        endcase
        return w;
    endfunction

    offset_flag_decode u_decode (
        .count    (s_q.count),
        .emptyOff (s_q.emptyOff),
        .fullOff  (s_q.fullOff),
        .fallThru (s_q.fallThru),
        .flags    (decFlags)
    );

    // Pin patterns; offset ones need exact matches, so an overlapped offset read and write does nothing
    always_comb begin
        offWr    = !dev.offset_load_sel && !dev.write_enable_n && dev.read_enable_n
                   && dev.serial_enable_n && !s_q.serialLd;
        offRd    = !dev.offset_load_sel && dev.write_enable_n && !dev.read_enable_n
                   && dev.serial_enable_n;
        serShift = !dev.offset_load_sel && !dev.serial_enable_n && dev.write_enable_n
                   && dev.read_enable_n && s_q.serialLd;
        capacity = s_q.fallThru ? fifo_flag_pkg::FULL_FT : fifo_flag_pkg::FULL_STD;
        memWr    = dev.offset_load_sel && !dev.write_enable_n
                   && ({1'b0, s_q.count} != capacity);
        memRd    = dev.offset_load_sel && !dev.read_enable_n
                   && (s_q.count != 18'h00000);
    end

    // Next state of the whole block
    always_comb begin
        s_d    = s_q;
        serIdx = 5'h00;
        // Word count stands in for the memory array, which lives outside
        case ({memWr, memRd})
            2'b10:   s_d.count = s_q.count + 18'h00001;
            2'b01:   s_d.count = s_q.count - 18'h00001;
            default: s_d.count = s_q.count;
        endcase
        if (offWr) begin
            case (s_q.wrPtr)
                fifo_flag_pkg::PTR_EMPTY_LSB: s_d.emptyOff[8:0]  = dev.data_in[8:0];
                fifo_flag_pkg::PTR_EMPTY_MSB: s_d.emptyOff[16:9] = dev.data_in[7:0];
                fifo_flag_pkg::PTR_FULL_LSB:  s_d.fullOff[8:0]   = dev.data_in[8:0];
                fifo_flag_pkg::PTR_FULL_MSB:  s_d.fullOff[16:9]  = dev.data_in[7:0];
                default:                      s_d.emptyOff       = s_q.emptyOff;
            endcase
            // Pointer is untouched by memory traffic, so writes resume in place
            s_d.wrPtr = fifo_flag_pkg::offPtr_t'(s_q.wrPtr + 2'h1);
        end
        if (offRd) begin
            s_d.dataOut = offWord(s_q.rdPtr, s_q.emptyOff, s_q.fullOff);
            s_d.rdPtr   = fifo_flag_pkg::offPtr_t'(s_q.rdPtr + 2'h1);
        end
        // Settling count for partial flags after a full serial set
        if (s_q.settle != 2'h0) begin
            s_d.settle = s_q.settle - 2'h1;
        end
        if (serShift) begin
            // Low half goes to the empty offset, high half to the full offset
            if (s_q.serCnt < fifo_flag_pkg::SER_SPLIT) begin
                serIdx = s_q.serCnt[4:0];
                s_d.emptyOff[serIdx] = dev.serial_in;
            end else begin
                serIdx = 5'(s_q.serCnt - fifo_flag_pkg::SER_SPLIT);
                s_d.fullOff[serIdx] = dev.serial_in;
            end
            // Position survives pauses, so shifting resumes at the next bit
            if (s_q.serCnt == fifo_flag_pkg::SER_LAST) begin
                s_d.serCnt = 6'h00;
                s_d.settle = fifo_flag_pkg::FLAG_SETTLE;
            end else begin
                s_d.serCnt = s_q.serCnt + 6'h01;
            end
        end
        // Fixed flags track the count; partial flags freeze during a serial load and its settling
        s_d.flags[fifo_flag_pkg::FL_FF] = decFlags[fifo_flag_pkg::FL_FF];
        s_d.flags[fifo_flag_pkg::FL_HF] = decFlags[fifo_flag_pkg::FL_HF];
        s_d.flags[fifo_flag_pkg::FL_EF] = decFlags[fifo_flag_pkg::FL_EF];
        s_d.flags[fifo_flag_pkg::FL_IR] = decFlags[fifo_flag_pkg::FL_IR];
        s_d.flags[fifo_flag_pkg::FL_OR] = decFlags[fifo_flag_pkg::FL_OR];
        if (s_q.serCnt == 6'h00 && s_q.settle == 2'h0) begin
            s_d.flags[fifo_flag_pkg::FL_PAF] = decFlags[fifo_flag_pkg::FL_PAF];
            s_d.flags[fifo_flag_pkg::FL_PAE] = decFlags[fifo_flag_pkg::FL_PAE];
        end
        // Partial reset empties the count and keeps offsets and pointers
        if (!dev.partial_reset_n) begin
            s_d.count = 18'h00000;
            s_d.flags = fifo_flag_pkg::FLAGS_RESET;
        end
        // Master reset samples the straps; only here and at rst_n may the method change
        if (!dev.master_reset_n) begin
            s_d.serialLd = dev.offset_load_sel;
            s_d.fallThru = dev.fall_through_sel;
            s_d.emptyOff = dev.offset_load_sel ? fifo_flag_pkg::OFF_DEF_SER
                                               : fifo_flag_pkg::OFF_DEF_PAR;
            s_d.fullOff  = dev.offset_load_sel ? fifo_flag_pkg::OFF_DEF_SER
                                               : fifo_flag_pkg::OFF_DEF_PAR;
            s_d.wrPtr    = fifo_flag_pkg::PTR_EMPTY_LSB;
            s_d.rdPtr    = fifo_flag_pkg::PTR_EMPTY_LSB;
            s_d.serCnt   = 6'h00;
            s_d.settle   = 2'h0;
            s_d.count    = 18'h00000;
            s_d.dataOut  = 18'h00000;
            s_d.flags    = fifo_flag_pkg::FLAGS_RESET;
        end
    end

    // State register; reset leaves standard mode with parallel defaults
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q.serialLd <= 1'b0;
            s_q.fallThru <= 1'b0;
            s_q.emptyOff <= fifo_flag_pkg::OFF_DEF_PAR;
            s_q.fullOff  <= fifo_flag_pkg::OFF_DEF_PAR;
            s_q.wrPtr    <= fifo_flag_pkg::PTR_EMPTY_LSB;
            s_q.rdPtr    <= fifo_flag_pkg::PTR_EMPTY_LSB;
            s_q.serCnt   <= 6'h00;
            s_q.settle   <= 2'h0;
            s_q.count    <= 18'h00000;
            s_q.dataOut  <= 18'h00000;
            s_q.flags    <= fifo_flag_pkg::FLAGS_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // All outputs come straight from flops
    assign dev.data_out          = s_q.dataOut;
    assign dev.full_flag         = s_q.flags[fifo_flag_pkg::FL_FF];
    assign dev.prog_almost_full  = s_q.flags[fifo_flag_pkg::FL_PAF];
    assign dev.half_full_flag    = s_q.flags[fifo_flag_pkg::FL_HF];
    assign dev.prog_almost_empty = s_q.flags[fifo_flag_pkg::FL_PAE];
    assign dev.empty_flag        = s_q.flags[fifo_flag_pkg::FL_EF];
    assign dev.input_ready       = s_q.flags[fifo_flag_pkg::FL_IR];
    assign dev.output_ready      = s_q.flags[fifo_flag_pkg::FL_OR];
endmodule
`default_nettype wire

// *** src/fifo_flag_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module fifo_flag_host (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    fifo_flag_if.host        pins
);
    typedef struct packed {
        logic        ftStrap;
        logic        ldStrap;
        logic        apWrite;
        logic [3:0]  apAddr;
        logic        capPend;
        logic [17:0] rdata;
        logic [31:0] hrdata;
        logic        loadSel;
        logic        wenN;
        logic        renN;
        logic        senN;
        logic        serIn;
        logic        mrN;
        logic        prN;
        logic [17:0] dataIn;
    } hostState_t;

    hostState_t            h_q;
    hostState_t            h_d;
    fifo_flag_pkg::hostOp_t op;
    logic                  addrPhase;
    logic [31:0]           status;

    // Each command drives its pin pattern for exactly one cycle
    always_comb begin
        h_d       = h_q;
        addrPhase = hsel && htrans[1] && hready;
        op        = fifo_flag_pkg::hostOp_t'(hwdata[fifo_flag_pkg::CMD_OP_LSB +: 3]);
        status    = {25'h0000000, pins.full_flag, pins.prog_almost_full, pins.half_full_flag,
                     pins.prog_almost_empty, pins.empty_flag, pins.input_ready,
                     pins.output_ready};
        h_d.loadSel = 1'b1;
        h_d.wenN    = 1'b1;
        h_d.renN    = 1'b1;
        h_d.senN    = 1'b1;
        h_d.mrN     = 1'b1;
        h_d.prN     = 1'b1;
        // Capture is armed in the cycle after the read pattern stood
        h_d.capPend = !h_q.loadSel && !h_q.renN;
        // Offset readback lands on data_out one edge after the read pattern
        if (h_q.capPend) begin
            h_d.rdata = pins.data_out;
        end
        // Data phase of a write
        if (h_q.apWrite) begin
            if (h_q.apAddr == fifo_flag_pkg::REG_CTRL) begin
                h_d.ftStrap = hwdata[fifo_flag_pkg::CTRL_FT_BIT];
                h_d.ldStrap = hwdata[fifo_flag_pkg::CTRL_LD_BIT];
            end else if (h_q.apAddr == fifo_flag_pkg::REG_CMD) begin
                h_d.dataIn = hwdata[17:0];
                h_d.serIn  = hwdata[0];
                case (op)
                    fifo_flag_pkg::OP_MEM_WR:      h_d.wenN = 1'b0;
                    fifo_flag_pkg::OP_MEM_RD:      h_d.renN = 1'b0;
                    fifo_flag_pkg::OP_OFF_WR: begin
                        h_d.loadSel = 1'b0;
                        h_d.wenN    = 1'b0;
                    end
                    fifo_flag_pkg::OP_OFF_RD: begin
                        h_d.loadSel = 1'b0;
                        h_d.renN    = 1'b0;
                    end
                    fifo_flag_pkg::OP_SER_BIT: begin
                        h_d.loadSel = 1'b0;
                        h_d.senN    = 1'b0;
                    end
                    fifo_flag_pkg::OP_MASTER_RST: begin
                        h_d.loadSel = h_q.ldStrap;
                        h_d.mrN     = 1'b0;
                    end
                    fifo_flag_pkg::OP_PARTIAL_RST: h_d.prN = 1'b0;
                    default:                       h_d.prN = 1'b1;
                endcase
            end
        end
        // Zero-wait slave: register the address phase, prepare read data
        h_d.apWrite = addrPhase && hwrite;
        h_d.apAddr  = haddr[3:0];
        if (addrPhase && !hwrite) begin
            case (haddr[3:0])
                fifo_flag_pkg::REG_CTRL:   h_d.hrdata = {30'h00000000, h_q.ldStrap,
                                                         h_q.ftStrap};
                fifo_flag_pkg::REG_STATUS: h_d.hrdata = status;
                fifo_flag_pkg::REG_RDATA:  h_d.hrdata = {14'h0000, h_q.rdata};
                default:                   h_d.hrdata = 32'h00000000;
            endcase
        end
    end

    // Master reset pin held low while the host itself is in reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            h_q         <= '0;
            h_q.wenN    <= 1'b1;
            h_q.renN    <= 1'b1;
            h_q.senN    <= 1'b1;
            h_q.prN     <= 1'b1;
        end else begin
            h_q <= h_d;
        end
    end

    assign hreadyout             = 1'b1;
    assign hresp                 = 1'b0;
    assign hrdata                = h_q.hrdata;
    assign pins.offset_load_sel  = h_q.loadSel;
    assign pins.write_enable_n   = h_q.wenN;
    assign pins.read_enable_n    = h_q.renN;
    assign pins.serial_enable_n  = h_q.senN;
    assign pins.serial_in        = h_q.serIn;
    assign pins.master_reset_n   = h_q.mrN;
    assign pins.partial_reset_n  = h_q.prN;
    assign pins.fall_through_sel = h_q.ftStrap;
    assign pins.data_in          = h_q.dataIn;
endmodule
`default_nettype wire

// *** src/fifo_flag_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface fifo_flag_if;
    logic        offset_load_sel;
    logic        write_enable_n;
    logic        read_enable_n;
    logic        serial_enable_n;
    logic        serial_in;
    logic        master_reset_n;
    logic        partial_reset_n;
    logic        fall_through_sel;
    logic [17:0] data_in;
    logic [17:0] data_out;
    logic        full_flag;
    logic        input_ready;
    logic        empty_flag;
    logic        output_ready;
    logic        half_full_flag;
    logic        prog_almost_full;
    logic        prog_almost_empty;

    modport device (
        input  offset_load_sel, write_enable_n, read_enable_n, serial_enable_n,
        input  serial_in, master_reset_n, partial_reset_n, fall_through_sel, data_in,
        output data_out, full_flag, input_ready, empty_flag, output_ready,
        output half_full_flag, prog_almost_full, prog_almost_empty
    );
    modport host (
        output offset_load_sel, write_enable_n, read_enable_n, serial_enable_n,
        output serial_in, master_reset_n, partial_reset_n, fall_through_sel, data_in,
        input  data_out, full_flag, input_ready, empty_flag, output_ready,
        input  half_full_flag, prog_almost_full, prog_almost_empty
    );
endinterface
`default_nettype wire

// *** src/fifo_flag_pkg.sv ***
package fifo_flag_pkg;
    // Geometry of the shallower organisation
    localparam int          DATA_W       = 18;
    localparam int          OFF_W        = 17;
    localparam int          CNT_W        = 18;
    localparam int          OFF_LSB_W    = 9;
    localparam int          OFF_MSB_W    = 8;
    localparam logic [5:0]  SER_LAST     = 6'h21;
    localparam logic [5:0]  SER_SPLIT    = 6'h11;
    // Word-count thresholds
    localparam logic [18:0] HALF_STD     = 19'h10001;
    localparam logic [18:0] HALF_FT      = 19'h10002;
    localparam logic [18:0] FULL_STD     = 19'h20000;
    localparam logic [18:0] FULL_FT      = 19'h20001;
    // Reset values
    localparam logic [16:0] OFF_DEF_SER  = 17'h003ff;
    localparam logic [16:0] OFF_DEF_PAR  = 17'h0007f;
    localparam logic [6:0]  FLAGS_RESET  = 7'h71;
    localparam logic [1:0]  FLAG_SETTLE  = 2'h2;
    // Flag vector positions: {ff, paf, hf, pae, ef, ir, or}
    localparam int          FL_FF        = 6;
    localparam int          FL_PAF       = 5;
    localparam int          FL_HF        = 4;
    localparam int          FL_PAE       = 3;
    localparam int          FL_EF        = 2;
    localparam int          FL_IR        = 1;
    localparam int          FL_OR        = 0;
    // Controller register map and fields
    localparam logic [3:0]  REG_CTRL     = 4'h0;
    localparam logic [3:0]  REG_CMD      = 4'h4;
    localparam logic [3:0]  REG_STATUS   = 4'h8;
    localparam logic [3:0]  REG_RDATA    = 4'hc;
    localparam int          CTRL_FT_BIT  = 0;
    localparam int          CTRL_LD_BIT  = 1;
    localparam int          CMD_OP_LSB   = 18;

    typedef enum logic [1:0] {
        PTR_EMPTY_LSB,
        PTR_EMPTY_MSB,
        PTR_FULL_LSB,
        PTR_FULL_MSB
    } offPtr_t;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_MEM_WR,
        OP_MEM_RD,
        OP_OFF_WR,
        OP_OFF_RD,
        OP_SER_BIT,
        OP_MASTER_RST,
        OP_PARTIAL_RST
    } hostOp_t;
endpackage

// *** src/offset_flag_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module offset_flag_decode (
    input  wire logic [17:0] count,
    input  wire logic [16:0] emptyOff,
    input  wire logic [16:0] fullOff,
    input  wire logic        fallThru,
    output logic      [6:0]  flags
);
    logic [18:0] cnt;
    logic [18:0] eOff;
    logic [18:0] fOff;

    // Active-low flags from the word count; widened so D-m never underflows
    always_comb begin
        cnt  = {1'b0, count};
        eOff = {2'b00, emptyOff};
        fOff = {2'b00, fullOff};
        flags = fifo_flag_pkg::FLAGS_RESET;
        if (fallThru) begin
            flags[fifo_flag_pkg::FL_OR]  = (cnt == 19'h00000);
            flags[fifo_flag_pkg::FL_PAE] = (cnt > eOff + 19'h00001);
            flags[fifo_flag_pkg::FL_HF]  = (cnt < fifo_flag_pkg::HALF_FT);
            flags[fifo_flag_pkg::FL_PAF] = (cnt < fifo_flag_pkg::FULL_FT - fOff);
            flags[fifo_flag_pkg::FL_IR]  = (cnt == fifo_flag_pkg::FULL_FT);
        end else begin
            flags[fifo_flag_pkg::FL_EF]  = (cnt != 19'h00000);
            flags[fifo_flag_pkg::FL_PAE] = (cnt > eOff);
            flags[fifo_flag_pkg::FL_HF]  = (cnt < fifo_flag_pkg::HALF_STD);
            flags[fifo_flag_pkg::FL_PAF] = (cnt < fifo_flag_pkg::FULL_STD - fOff);
            flags[fifo_flag_pkg::FL_FF]  = (cnt != fifo_flag_pkg::FULL_STD);
        end
    end
endmodule
`default_nettype wire

// *** testbench/fifo_flag_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module fifo_flag_monitor (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        offset_load_sel,
    input wire logic        write_enable_n,
    input wire logic        read_enable_n,
    input wire logic        serial_enable_n,
    input wire logic        master_reset_n,
    input wire logic        partial_reset_n,
    input wire logic [17:0] data_out,
    input wire logic        full_flag,
    input wire logic        input_ready,
    input wire logic        empty_flag,
    input wire logic        output_ready,
    input wire logic        half_full_flag,
    input wire logic        prog_almost_full,
    input wire logic        prog_almost_empty
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Offset readback pattern on the pins
    wire offRd = !offset_load_sel && write_enable_n && !read_enable_n && serial_enable_n;
    sequence offRd_s;
        offRd;
    endsequence
    // Output checked as cleared first, flags checked one edge later
    sequence mrsDone_s;
        data_out == 18'h00000 ##1 (!prog_almost_empty && prog_almost_full && half_full_flag);
    endsequence
    rd_upper_a: assert property (offRd_s |=> data_out[17:9] == 9'h000)
        else $error("offset readback has upper bits set");
    out_hold_a: assert property ((!offRd && master_reset_n && partial_reset_n) |=> $stable(data_out))
        else $error("data output moved without a readback");
    mrs_flags_a: assert property (!master_reset_n |=> mrsDone_s)
        else $error("master reset did not restore flags");
    no_rdwr_a: assert property (offset_load_sel || write_enable_n || read_enable_n)
        else $error("offset read and write at once");
    full_flags_a: assert property (!full_flag |-> !prog_almost_full && !half_full_flag && empty_flag)
        else $error("full without other flags");
    empty_pae_a: assert property ((!empty_flag && output_ready) |-> !prog_almost_empty && half_full_flag && prog_almost_full)
        else $error("empty but partial flags wrong");
    ft_or_a: assert property (!output_ready |-> !empty_flag && full_flag)
        else $error("standard flags active in fall-through");
    ir_full_a: assert property (input_ready |-> full_flag && !empty_flag && !prog_almost_full)
        else $error("input not ready while not full");
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        rdPhase = 1'b0;
    logic [31:0] expQ[$];
    logic [31:0] seed = 32'd91063;
    logic [16:0] nOff;
    logic [16:0] mOff;
    int          fails = 0;
    int          n_compared = 0;
    int          rp = 0;
    fifo_flag_if bus ();
    always #5 clk_sys = ~clk_sys;
    fifo_flag_device i_fifo_flag_device (.clk_sys(clk_sys), .rst_n(rst_n), .dev(bus));
    fifo_flag_host i_fifo_flag_host (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .pins(bus));
    fifo_flag_monitor i_fifo_flag_monitor (.clk_sys(clk_sys), .rst_n(rst_n),
        .offset_load_sel(bus.offset_load_sel), .write_enable_n(bus.write_enable_n),
        .read_enable_n(bus.read_enable_n), .serial_enable_n(bus.serial_enable_n),
        .master_reset_n(bus.master_reset_n), .partial_reset_n(bus.partial_reset_n),
        .data_out(bus.data_out), .full_flag(bus.full_flag), .input_ready(bus.input_ready),
        .empty_flag(bus.empty_flag), .output_ready(bus.output_ready),
        .half_full_flag(bus.half_full_flag), .prog_almost_full(bus.prog_almost_full),
        .prog_almost_empty(bus.prog_almost_empty));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Single transfer; no wait count assumed, the watchdog cuts a hang
    task automatic ahb(input logic wr, input logic [3:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {28'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        rdPhase <= !wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rdPhase <= 1'b0;
    endtask
    task automatic cmd(input logic [2:0] op, input logic [17:0] d);
        ahb(1'b1, 4'h4, {11'h0, op, d});
    endtask
    // Pins act two edges after the write, so let them settle first
    task automatic chk(input logic [3:0] a, input logic [31:0] e);
        repeat (4) @(posedge clk_sys);
        expQ.push_back(e);
        ahb(1'b0, a, 32'h0);
    endtask
    task automatic offRd();
        logic [31:0] e;
        e = 32'(rp[0] ? (rp[1] ? mOff[16:9] : nOff[16:9]) : (rp[1] ? mOff[8:0] : nOff[8:0]));
        cmd(3'h4, 18'h0);
        chk(4'hc, e);
        rp = (rp + 1) % 4;
    endtask
    task automatic mstr(input logic [31:0] ctrl);
        ahb(1'b1, 4'h0, ctrl);
        cmd(3'h6, 18'h0);
        rp = 0;
        nOff = ctrl[1] ? 17'h003ff : 17'h0007f;
        mOff = nOff;
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Result watcher takes the oldest note at each read data phase
    always @(posedge clk_sys) begin
        if (rdPhase && hreadyout === 1'b1) begin
            cmp(hrdata, expQ.pop_front());
        end
    end
    initial begin
        logic [33:0] bits;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        nOff = 17'h0007f;
        mOff = 17'h0007f;
        chk(4'h8, 32'h71);
        repeat (8) offRd();
        // Small empty offset so the threshold is reachable
        nOff = 17'(xs() % 32'd8) + 17'h1;
        mOff = 17'(xs() & 32'h1ff);
        cmd(3'h3, {9'h0, nOff[8:0]});
        cmd(3'h3, {10'h0, nOff[16:9]});
        cmd(3'h1, 18'(xs()));
        cmd(3'h3, {9'h0, mOff[8:0]});
        cmd(3'h3, {10'h0, mOff[16:9]});
        repeat (4) offRd();
        repeat (nOff - 17'h1) cmd(3'h1, 18'(xs()));
        chk(4'h8, 32'h75);
        cmd(3'h1, 18'h0);
        chk(4'h8, 32'h7d);
        offRd();
        cmd(3'h7, 18'h0);
        offRd();
        chk(4'h8, 32'h71);
        mstr(32'h2);
        cmd(3'h3, 18'h5);
        repeat (4) offRd();
        bits = 34'({xs(), xs()});
        for (int i = 0; i < 34; i++) begin
            if (i == 20) cmd(3'h1, 18'h3);
            cmd(3'h5, {17'h0, bits[i]});
        end
        {mOff, nOff} = bits;
        repeat (4) offRd();
        mstr(32'h1);
        chk(4'h8, 32'h71);
        cmd(3'h1, 18'h1);
        chk(4'h8, 32'h70);
        cmd(3'h2, 18'h0);
        chk(4'h8, 32'h71);
        offRd();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        end_sim();
    end
endmodule
`default_nettype wire
